// ==== hw/shear_test_pkg.sv ====
// Constants for the shear test and error display logic.
// Assumes a 250 MHz pclk; all offsets are APB byte addresses.
package shear_test_pkg;
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_KEYS = 8'h04;
    localparam logic [7:0] OFF_GAIN_COR = 8'h08;
    localparam logic [7:0] OFF_GAIN_TOT = 8'h0C;
    localparam logic [7:0] OFF_OFFS_COR = 8'h10;
    localparam logic [7:0] OFF_OFFS_TOT = 8'h14;
    localparam logic [7:0] OFF_DIR = 8'h18;
    localparam logic [7:0] OFF_LINE_CNT = 8'h1C;
    localparam logic [7:0] OFF_CARR_CNT = 8'h20;
    localparam logic [7:0] OFF_POS_ERR = 8'h24;
    localparam logic [7:0] OFF_LEDS = 8'h28;
    localparam logic [7:0] OFF_INPUTS = 8'h2C;
    localparam logic [7:0] OFF_PAR_IN = 8'h30;
    localparam logic [7:0] OFF_STORE = 8'h34;
    // Mode register values
    localparam logic [3:0] MODE_RUN = 4'h0;
    localparam logic [3:0] MODE_ADJUST = 4'h1;
    localparam logic [3:0] MODE_LINE_DIR = 4'h2;
    localparam logic [3:0] MODE_CARR_DIR = 4'h3;
    localparam logic [3:0] MODE_OFFS_COR = 4'h4;
    localparam logic [3:0] MODE_GAIN_COR = 4'h5;
    localparam logic [3:0] MODE_OFFS_TOT = 4'h6;
    localparam logic [3:0] MODE_GAIN_TOT = 4'h7;
    localparam logic [3:0] MODE_IND_TEST = 4'h8;
    localparam logic [3:0] MODE_CTRL_IN = 4'h9;
    localparam logic [3:0] MODE_PAR_IN = 4'hA;
    // Key bits in the key register
    localparam int KEY_A = 0;
    localparam int KEY_B = 1;
    localparam int KEY_C = 2;
    localparam int KEY_STORE = 3;
    localparam int KEY_VIEW = 4;
    // Reset values
    localparam logic [23:0] GAIN_COR_RST = 24'h0000C8;
    localparam logic [23:0] GAIN_TOT_RST = 24'h000000;
    localparam logic [23:0] OFFS_RST = 24'h000000;
    // Scroll timing: one step per interval while a key is held
    localparam int CLK_HZ = 250_000_000;
    localparam int SCROLL_MS = 10;
    localparam int SCROLL_CYC = CLK_HZ / 1000 * SCROLL_MS;
    // Indicator test step time
    localparam int STEP_MS = 200;
    localparam int STEP_CYC = CLK_HZ / 1000 * STEP_MS;
    // Encoder rate limit and the least pulse spacing it implies
    localparam int ENC_MAX_KHZ = 300;
    localparam int ENC_MIN_CYC = CLK_HZ / (ENC_MAX_KHZ * 1000);
    // Simulated error for the correction-gain test, and offset scale
    localparam logic [15:0] GAIN_TEST_ERR = 16'h0400;
    localparam int OFFS_TEST_SCALE = 100;
    // Bar graph band width in counts
    localparam int BAND_W = 8;
    localparam int NUM_LEDS = 8;
    localparam int NUM_OUTS = 8;
    localparam int NUM_CIN = 12;
endpackage

// ==== hw/shear_test_display.sv ====
// Keypad test modes, encoder direction test and eight-LED error bar.
// Assumes quadrature encoder inputs already synchronous to pclk.
`timescale 1ns/10ps
//Function
// - Adjust mode: held A/B scrolls gains
// - Adjust mode store key saves gains
// - Adjust mode key C recentres bar
// - Line direction test: up/down encoder counter
// - A inverts, B clears, store saves direction
// - Same direction test for carriage encoder
// - Offset test scrolls, output scaled hundredfold
// - Gain test scrolls, simulated 1024 error
// - Total offset and gain tests scroll
// - Indicator test walks LEDs and outputs
// - Inputs shown hex or one-of-12
// - Parallel lines shown on display
// - Eight LEDs show position error
// - Zero error lights both centre greens
// - Bands of eight counts per LED
// - Bar up positive, down negative
// - Polarity inverted for reverse motion
// - Counting handles up to 300 kHz
module shear_test_display
    import shear_test_pkg::*;
#(
    parameter int SCROLL_CYCLES = SCROLL_CYC,
    parameter int STEP_CYCLES = STEP_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic line_a,
    input wire logic line_b,
    input wire logic carr_a,
    input wire logic carr_b,
    input wire logic [15:0] pos_err,
    input wire logic reverse_motion,
    input wire logic [NUM_CIN-1:0] ctrl_in,
    input wire logic [15:0] par_in,
    output logic [NUM_LEDS-1:0] leds,
    output logic [NUM_OUTS-1:0] ctrl_out,
    output logic ctrl_out_test,
    output logic store_req,
    output logic [15:0] corr_test_err,
    output logic [23:0] offs_test_out,
    output logic [23:0] display_val
);
    logic wr_en;
    logic [3:0] mode_q;
    logic [4:0] keys_q;
    logic [4:0] keys_prev_q;
    logic [4:0] key_edge;
    logic [23:0] gain_cor_q;
    logic [23:0] gain_tot_q;
    logic [23:0] offs_cor_q;
    logic [23:0] offs_tot_q;
    logic line_dir_q;
    logic carr_dir_q;
    logic line_inv_q;
    logic carr_inv_q;
    logic [15:0] line_cnt_q;
    logic [15:0] carr_cnt_q;
    logic [1:0] line_ab_q;
    logic [1:0] carr_ab_q;
    logic line_step;
    logic line_up;
    logic carr_step;
    logic carr_up;
    logic [31:0] scroll_cnt_q;
    logic scroll_tick;
    logic [31:0] step_cnt_q;
    logic [4:0] walk_q;
    logic recentre_q;
    logic store_q;
    logic [NUM_LEDS-1:0] bar_leds;
    logic [15:0] err_mag;
    logic err_neg;
    logic [3:0] cin_idx;
    logic in_scroll;
    logic view_q;

    assign wr_en = psel && penable && pwrite;
    assign pready = 1'b1;
    assign key_edge = keys_q & ~keys_prev_q;
    assign in_scroll = mode_q inside {MODE_ADJUST, MODE_OFFS_COR,
        MODE_GAIN_COR, MODE_OFFS_TOT, MODE_GAIN_TOT};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= MODE_RUN;
            keys_q <= 5'h00;
            keys_prev_q <= 5'h00;
        end else begin
            keys_prev_q <= keys_q;
            if (wr_en && paddr == OFF_MODE) begin
                mode_q <= pwdata[3:0];
            end
            if (wr_en && paddr == OFF_KEYS) begin
                keys_q <= pwdata[4:0];
            end
        end
    end

    // Auto-repeat rate for held keys; restarts so a tap gives one step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scroll_cnt_q <= 32'h0;
        end else if (!(keys_q[KEY_A] || keys_q[KEY_B])) begin
            scroll_cnt_q <= 32'h0;
        end else if (scroll_cnt_q >= 32'(SCROLL_CYCLES - 1)) begin
            scroll_cnt_q <= 32'h0;
        end else begin
            scroll_cnt_q <= scroll_cnt_q + 32'h1;
        end
    end
    assign scroll_tick = (keys_q[KEY_A] || keys_q[KEY_B])
        && scroll_cnt_q == 32'h0;

    // Gain and offset scrolling; gains hold at zero going down, all else wraps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gain_cor_q <= GAIN_COR_RST;
            gain_tot_q <= GAIN_TOT_RST;
            offs_cor_q <= OFFS_RST;
            offs_tot_q <= OFFS_RST;
        end else if (in_scroll && scroll_tick) begin
            case (mode_q)
                MODE_ADJUST, MODE_GAIN_COR: begin
                    if (keys_q[KEY_A]) begin
                        gain_cor_q <= gain_cor_q + 24'h1;
                    end else if (gain_cor_q != 24'h0) begin
                        gain_cor_q <= gain_cor_q - 24'h1;
                    end
                    if (mode_q == MODE_ADJUST) begin
                        if (keys_q[KEY_A]) begin
                            gain_tot_q <= gain_tot_q + 24'h1;
                        end else if (gain_tot_q != 24'h0) begin
                            gain_tot_q <= gain_tot_q - 24'h1;
                        end
                    end
                end
                MODE_GAIN_TOT: begin
                    if (keys_q[KEY_A]) begin
                        gain_tot_q <= gain_tot_q + 24'h1;
                    end else if (gain_tot_q != 24'h0) begin
                        gain_tot_q <= gain_tot_q - 24'h1;
                    end
                end
                MODE_OFFS_COR: begin
                    offs_cor_q <= keys_q[KEY_A] ? offs_cor_q + 24'h1
                        : offs_cor_q - 24'h1;
                end
                MODE_OFFS_TOT: begin
                    offs_tot_q <= keys_q[KEY_A] ? offs_tot_q + 24'h1
                        : offs_tot_q - 24'h1;
                end
                default: begin
                end
            endcase
        end else if (wr_en) begin
            if (paddr == OFF_GAIN_COR) gain_cor_q <= pwdata[23:0];
            if (paddr == OFF_GAIN_TOT) gain_tot_q <= pwdata[23:0];
            if (paddr == OFF_OFFS_COR) offs_cor_q <= pwdata[23:0];
            if (paddr == OFF_OFFS_TOT) offs_tot_q <= pwdata[23:0];
        end
    end

    // Quadrature decode, one count per edge of either channel
    assign line_step = (line_ab_q != {line_a, line_b});
    assign line_up = (line_ab_q[1] ^ line_b) ^ line_inv_q;
    assign carr_step = (carr_ab_q != {carr_a, carr_b});
    assign carr_up = (carr_ab_q[1] ^ carr_b) ^ carr_inv_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_ab_q <= 2'b00;
            carr_ab_q <= 2'b00;
            line_cnt_q <= 16'h0;
            carr_cnt_q <= 16'h0;
        end else begin
            line_ab_q <= {line_a, line_b};
            carr_ab_q <= {carr_a, carr_b};
            if (mode_q == MODE_LINE_DIR && key_edge[KEY_B]) begin
                line_cnt_q <= 16'h0;
            end else if (mode_q == MODE_LINE_DIR && line_step) begin
                line_cnt_q <= line_up ? line_cnt_q + 16'h1
                    : line_cnt_q - 16'h1;
            end
            if (mode_q == MODE_CARR_DIR && key_edge[KEY_B]) begin
                carr_cnt_q <= 16'h0;
            end else if (mode_q == MODE_CARR_DIR && carr_step) begin
                carr_cnt_q <= carr_up ? carr_cnt_q + 16'h1
                    : carr_cnt_q - 16'h1;
            end
        end
    end

    // Working direction is edited by key A, stored by the store key
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_inv_q <= 1'b0;
            carr_inv_q <= 1'b0;
            line_dir_q <= 1'b0;
            carr_dir_q <= 1'b0;
        end else begin
            if (mode_q == MODE_LINE_DIR && key_edge[KEY_A]) begin
                line_inv_q <= ~line_inv_q;
            end else if (mode_q != MODE_LINE_DIR) begin
                line_inv_q <= line_dir_q;
            end
            if (mode_q == MODE_CARR_DIR && key_edge[KEY_A]) begin
                carr_inv_q <= ~carr_inv_q;
            end else if (mode_q != MODE_CARR_DIR) begin
                carr_inv_q <= carr_dir_q;
            end
            if (mode_q == MODE_LINE_DIR && key_edge[KEY_STORE]) begin
                line_dir_q <= line_inv_q;
            end else if (wr_en && paddr == OFF_DIR) begin
                line_dir_q <= pwdata[0];
            end
            if (mode_q == MODE_CARR_DIR && key_edge[KEY_STORE]) begin
                carr_dir_q <= carr_inv_q;
            end else if (wr_en && paddr == OFF_DIR) begin
                carr_dir_q <= pwdata[1];
            end
        end
    end

    // Store request pulse and bar recentring
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            store_q <= 1'b0;
            recentre_q <= 1'b0;
            view_q <= 1'b0;
        end else begin
            store_q <= key_edge[KEY_STORE] && (mode_q == MODE_ADJUST
                || mode_q == MODE_LINE_DIR
                || mode_q == MODE_CARR_DIR);
            // Key A touch toggles the view; leaving the mode drops it
            view_q <= (mode_q == MODE_CTRL_IN)
                && (view_q ^ key_edge[KEY_A]);
            if (mode_q == MODE_ADJUST && key_edge[KEY_C]) begin
                recentre_q <= 1'b1;
            end else if (mode_q != MODE_ADJUST || keys_q[KEY_A]
                    || keys_q[KEY_B]) begin
                recentre_q <= 1'b0;
            end
        end
    end
    assign store_req = store_q;

    // Indicator test walk: each LED then each output, on then off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_cnt_q <= 32'h0;
            walk_q <= 5'h0;
        end else if (mode_q != MODE_IND_TEST) begin
            step_cnt_q <= 32'h0;
            walk_q <= 5'h0;
        end else if (step_cnt_q >= 32'(STEP_CYCLES - 1)) begin
            step_cnt_q <= 32'h0;
            walk_q <= walk_q + 5'h1;
        end else begin
            step_cnt_q <= step_cnt_q + 32'h1;
        end
    end

    // Bar graph: sign, magnitude, bands of eight counts
    always_comb begin
        logic [15:0] e;
        int band;
        e = pos_err;
        band = 0;
        bar_leds = '0;
        err_neg = e[15] ^ reverse_motion;
        err_mag = e[15] ? 16'(-e) : e;
        band = int'(err_mag) / BAND_W;
        if (band > NUM_LEDS / 2 - 1) begin
            band = NUM_LEDS / 2 - 1;
        end
        if (err_mag == 16'h0 || recentre_q) begin
            bar_leds[NUM_LEDS/2] = 1'b1;
            bar_leds[NUM_LEDS/2-1] = 1'b1;
        end else if (!err_neg) begin
            bar_leds[NUM_LEDS/2] = 1'b1;
            bar_leds[NUM_LEDS/2 + band] = 1'b1;
        end else begin
            bar_leds[NUM_LEDS/2-1] = 1'b1;
            bar_leds[NUM_LEDS/2-1 - band] = 1'b1;
        end
    end

    always_comb begin
        cin_idx = 4'hF;
        for (int i = NUM_CIN - 1; i >= 0; i--) begin
            if (ctrl_in[i]) cin_idx = 4'(i);
        end
    end

    // LED, control, test and display outputs are registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            leds <= '0;
            ctrl_out <= '0;
            ctrl_out_test <= 1'b0;
            corr_test_err <= 16'h0;
            offs_test_out <= 24'h0;
            display_val <= 24'h0;
        end else begin
            ctrl_out_test <= (mode_q == MODE_IND_TEST);
            if (mode_q == MODE_IND_TEST) begin
                leds <= (walk_q < 5'(NUM_LEDS))
                    ? NUM_LEDS'(1) << walk_q[2:0] : '0;
                ctrl_out <= (walk_q >= 5'(NUM_LEDS)
                    && walk_q < 5'(NUM_LEDS + NUM_OUTS))
                    ? NUM_OUTS'(1) << walk_q[2:0] : '0;
            end else begin
                leds <= bar_leds;
                ctrl_out <= '0;
            end
            corr_test_err <= (mode_q == MODE_GAIN_COR)
                ? GAIN_TEST_ERR : 16'h0;
            offs_test_out <= (mode_q == MODE_OFFS_COR)
                ? 24'(offs_cor_q * OFFS_TEST_SCALE) : offs_cor_q;
            case (mode_q)
                MODE_ADJUST: display_val <= gain_cor_q;
                MODE_LINE_DIR: display_val <= {8'h0, line_cnt_q};
                MODE_CARR_DIR: display_val <= {8'h0, carr_cnt_q};
                MODE_OFFS_COR: display_val <= offs_cor_q;
                MODE_GAIN_COR: display_val <= gain_cor_q;
                MODE_OFFS_TOT: display_val <= offs_tot_q;
                MODE_GAIN_TOT: display_val <= gain_tot_q;
                MODE_CTRL_IN: display_val <= view_q
                    ? {20'h0, cin_idx} : {12'h0, ctrl_in};
                MODE_PAR_IN: display_val <= {8'h0, par_in};
                default: display_val <= 24'h0;
            endcase
        end
    end

    always_comb begin
        prdata = 32'h0;
        pslverr = 1'b0;
        case (paddr)
            OFF_MODE: prdata = {28'h0, mode_q};
            OFF_KEYS: prdata = {27'h0, keys_q};
            OFF_GAIN_COR: prdata = {8'h0, gain_cor_q};
            OFF_GAIN_TOT: prdata = {8'h0, gain_tot_q};
            OFF_OFFS_COR: prdata = {8'h0, offs_cor_q};
            OFF_OFFS_TOT: prdata = {8'h0, offs_tot_q};
            OFF_DIR: prdata = {30'h0, carr_dir_q, line_dir_q};
            OFF_LINE_CNT: prdata = {16'h0, line_cnt_q};
            OFF_CARR_CNT: prdata = {16'h0, carr_cnt_q};
            OFF_POS_ERR: prdata = {16'h0, pos_err};
            OFF_LEDS: prdata = {24'h0, leds};
            OFF_INPUTS: prdata = {20'h0, ctrl_in};
            OFF_PAR_IN: prdata = {16'h0, par_in};
            OFF_STORE: prdata = {31'h0, store_q};
            default: pslverr = psel && penable;
        endcase
    end

    a_zero_centre: assert property (@(posedge pclk) disable iff (!presetn)
        mode_q == MODE_RUN && pos_err == 16'h0 && !recentre_q
        |=> leds == 8'h18)
        else $error("zero error not centred");
    a_small_one_green: assert property (@(posedge pclk)
        disable iff (!presetn)
        mode_q == MODE_RUN && !recentre_q && !reverse_motion
        && pos_err == 16'h0005 |=> leds == 8'h10)
        else $error("small error wrong led");
    a_band_two: assert property (@(posedge pclk) disable iff (!presetn)
        mode_q == MODE_RUN && !recentre_q && !reverse_motion
        && pos_err == 16'h0008 |=> leds == 8'h30)
        else $error("second band wrong");
    a_neg_down: assert property (@(posedge pclk) disable iff (!presetn)
        mode_q == MODE_RUN && !recentre_q && !reverse_motion
        && pos_err == 16'hFFF9 |=> leds == 8'h08)
        else $error("negative error wrong side");
    a_reverse_flip: assert property (@(posedge pclk)
        disable iff (!presetn)
        mode_q == MODE_RUN && !recentre_q && reverse_motion
        && pos_err == 16'h0005 |=> leds == 8'h08)
        else $error("reverse not inverted");
    a_saturate_out: assert property (@(posedge pclk)
        disable iff (!presetn)
        mode_q == MODE_RUN && !recentre_q && !reverse_motion
        && pos_err == 16'h01F4 |=> leds == 8'h90)
        else $error("saturation wrong");
    a_gain_err: assert property (@(posedge pclk) disable iff (!presetn)
        mode_q == MODE_GAIN_COR |=> corr_test_err == 16'h0400)
        else $error("test error not 1024");
    a_clear_line: assert property (@(posedge pclk) disable iff (!presetn)
        mode_q == MODE_LINE_DIR && key_edge[KEY_B]
        |=> line_cnt_q == 16'h0)
        else $error("line counter not cleared");
    a_store_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        mode_q == MODE_ADJUST && key_edge[KEY_STORE] |=> store_req)
        else $error("store not requested");
    a_line_count: assert property (@(posedge pclk) disable iff (!presetn)
        mode_q == MODE_LINE_DIR && !key_edge[KEY_B] && line_step
        |=> line_cnt_q != $past(line_cnt_q))
        else $error("line counter not stepping");
endmodule // shear_test_display

// ==== verification/enc_model.sv ====
// Incremental encoder model driving one quadrature pair.
// Assumes the caller steps it from a pclk-synchronous process.
`timescale 1ns/10ps
module enc_model #(
    parameter int GAP = 834 // Spacing keeps below 300 kHz
) (
    input wire logic pclk,
    output logic a,
    output logic b
);
    logic [1:0] pos_q = 2'h0;
    // Gray sequence 00,01,11,10 so only one line moves per step
    assign a = pos_q[1];
    assign b = pos_q[1] ^ pos_q[0];
    task automatic step(input logic fwd);
        @(posedge pclk);
        pos_q <= fwd ? pos_q + 2'h1 : pos_q - 2'h1;
        repeat (GAP) @(posedge pclk);
    endtask
endmodule // enc_model

// ==== verification/tb_shear_test_display.sv ====
// Self-checking bench for the shear test and error display block.
// Assumes enc_model compiled first; this bench is the APB master.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
    err_count++; $display("mismatch %s exp %0h got %0h", nm, ex, got); \
    end end
module tb_shear_test_display;
    import shear_test_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic er, line_a, line_b, carr_a, carr_b, reverse_motion;
    logic [15:0] pos_err, par_in, corr_test_err;
    logic [11:0] ctrl_in;
    logic [7:0] leds, ctrl_out, acc_l, acc_o;
    logic ctrl_out_test, store_req;
    logic [23:0] offs_test_out, display_val;
    int err_count = 0;
    int n_tests = 0;
    int n_store = 0;
    int bad;
    enc_model line_enc (.pclk(pclk), .a(line_a), .b(line_b));
    enc_model carr_enc (.pclk(pclk), .a(carr_a), .b(carr_b));
    // Short scroll and step counts keep the run brief
    shear_test_display #(.SCROLL_CYCLES(4), .STEP_CYCLES(4)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .line_a(line_a),
        .line_b(line_b), .carr_a(carr_a), .carr_b(carr_b),
        .pos_err(pos_err), .reverse_motion(reverse_motion),
        .ctrl_in(ctrl_in), .par_in(par_in), .leds(leds),
        .ctrl_out(ctrl_out), .ctrl_out_test(ctrl_out_test),
        .store_req(store_req), .corr_test_err(corr_test_err),
        .offs_test_out(offs_test_out), .display_val(display_val));
    initial begin
        pclk = 0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) if (store_req === 1'b1) n_store++;
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        `CHK(nm, ex, rd)
    endtask
    // A press is a rising edge of the key bit, so set then clear it
    task automatic key(input int k);
        wr(OFF_KEYS, 32'h1 << k);
        wr(OFF_KEYS, 32'h0);
    endtask
    task automatic bar(input logic [15:0] e, input logic r,
                       input logic [7:0] x);
        pos_err <= e;
        reverse_motion <= r;
        repeat (3) @(posedge pclk);
        `CHK("leds", x, leds)
    endtask
    task automatic t_regs;
        rdc("gain_cor", OFF_GAIN_COR, 32'h000000C8);
        apb(1'b0, 8'h3C, 32'h0);
        `CHK("pslverr", 1'b1, er)
        `CHK("unmapped", 32'h0, rd)
    endtask
    task automatic t_bar;
        bar(16'h0000, 1'b0, 8'h18);
        bar(16'h0005, 1'b0, 8'h10);
        bar(16'h0008, 1'b0, 8'h30);
        bar(16'h0010, 1'b0, 8'h50);
        bar(16'hFFF9, 1'b0, 8'h08);
        bar(16'hFFF1, 1'b0, 8'h0C);
        bar(16'h01F4, 1'b0, 8'h90);
        bar(16'hFE0C, 1'b0, 8'h09);
        bar(16'h0005, 1'b1, 8'h08);
    endtask
    task automatic t_adjust;
        int s;
        wr(OFF_MODE, {28'h0, MODE_ADJUST});
        key(KEY_A);
        rdc("gain_cor", OFF_GAIN_COR, 32'h000000C9);
        rdc("gain_tot", OFF_GAIN_TOT, 32'h00000001);
        key(KEY_B);
        rdc("gain_cor", OFF_GAIN_COR, 32'h000000C8);
        `CHK("disp", 24'h0000C8, display_val)
        bar(16'h0032, 1'b0, 8'h90);
        key(KEY_C);
        repeat (2) @(posedge pclk);
        `CHK("leds", 8'h18, leds)
        s = n_store;
        key(KEY_STORE);
        repeat (3) @(posedge pclk);
        `CHK("store", s + 1, n_store)
        bar(16'h0000, 1'b0, 8'h18);
    endtask
    task automatic t_dir;
        wr(OFF_MODE, {28'h0, MODE_LINE_DIR});
        key(KEY_B);
        repeat (4) line_enc.step(1'b1);
        rdc("line_cnt", OFF_LINE_CNT, 32'h4);
        `CHK("disp", 24'h000004, display_val)
        key(KEY_A);
        repeat (2) line_enc.step(1'b1);
        rdc("line_cnt", OFF_LINE_CNT, 32'h2);
        key(KEY_B);
        rdc("line_cnt", OFF_LINE_CNT, 32'h0);
        key(KEY_STORE);
        rdc("dir", OFF_DIR, 32'h1);
        wr(OFF_MODE, {28'h0, MODE_CARR_DIR});
        key(KEY_B);
        repeat (3) carr_enc.step(1'b1);
        rdc("carr_cnt", OFF_CARR_CNT, 32'h3);
    endtask
    task automatic t_scroll;
        wr(OFF_MODE, {28'h0, MODE_OFFS_COR});
        wr(OFF_OFFS_COR, 32'h3);
        repeat (2) @(posedge pclk);
        `CHK("offs_out", 24'h00012C, offs_test_out)
        key(KEY_A);
        rdc("offs_cor", OFF_OFFS_COR, 32'h4);
        wr(OFF_MODE, {28'h0, MODE_GAIN_COR});
        repeat (2) @(posedge pclk);
        `CHK("corr_err", 16'h0400, corr_test_err)
        key(KEY_A);
        rdc("gain_cor", OFF_GAIN_COR, 32'h000000C9);
        wr(OFF_MODE, {28'h0, MODE_OFFS_TOT});
        key(KEY_A);
        rdc("offs_tot", OFF_OFFS_TOT, 32'h1);
        wr(OFF_MODE, {28'h0, MODE_GAIN_TOT});
        key(KEY_A);
        rdc("gain_tot", OFF_GAIN_TOT, 32'h1);
    endtask
    task automatic t_ind;
        wr(OFF_MODE, {28'h0, MODE_IND_TEST});
        acc_l = 8'h00;
        acc_o = 8'h00;
        bad = 0;
        // Leds still show the two-bit bar for one cycle after the write
        @(posedge pclk);
        // A full walk is 32 steps of 4 cycles
        repeat (200) @(negedge pclk) begin
            acc_l = acc_l | leds;
            acc_o = acc_o | ctrl_out;
            if ($countones({leds, ctrl_out}) > 1) bad++;
        end
        `CHK("ind_test", 1'b1, ctrl_out_test)
        `CHK("leds_seen", 8'hFF, acc_l)
        `CHK("outs_seen", 8'hFF, acc_o)
        `CHK("one_hot", 0, bad)
    endtask
    task automatic t_inputs;
        wr(OFF_MODE, {28'h0, MODE_CTRL_IN});
        ctrl_in <= 12'h0A4;
        repeat (3) @(posedge pclk);
        `CHK("cin_hex", 24'h0000A4, display_val)
        key(KEY_A);
        repeat (2) @(posedge pclk);
        `CHK("cin_one", 24'h000002, display_val)
        key(KEY_A);
        repeat (2) @(posedge pclk);
        `CHK("cin_back", 24'h0000A4, display_val)
        wr(OFF_MODE, {28'h0, MODE_PAR_IN});
        par_in <= 16'h1234;
        repeat (3) @(posedge pclk);
        `CHK("par_in", 24'h001234, display_val)
    endtask
    task automatic wrap_up;
        if (err_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        presetn = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = 8'h00; pwdata = 32'h0; pos_err = 16'h0000;
        reverse_motion = 0; ctrl_in = 12'h000; par_in = 16'h0000;
        repeat (20) @(posedge pclk);
        presetn <= 1;
        t_regs;
        t_bar;
        t_adjust;
        t_dir;
        t_scroll;
        t_ind;
        t_inputs;
        wrap_up;
    end
    // Encoder steps dominate, about 8000 cycles in all
    initial begin
        repeat (25000) @(posedge pclk);
        err_count++;
        wrap_up;
    end
endmodule // tb_shear_test_display
